// ===== mqes_top.sv
/*
 * measurement and questionable event status: two channels behind a
 * selector-addressed command port with read and write strobes.
 * assumes the command port is on i_sys_clk; source levels are asynchronous.
 */
`timescale 1ns/1ns
`include "mqes_regs.svh"
module mqes_top (
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_resetn,
  // event sources, asynchronous levels
  input  wire logic [`MQES_W-1:0]     i_meas_src,
  input  wire logic [`MQES_W-1:0]     i_ques_src,
  input  wire logic                   i_trace_buffer_full,
  input  wire logic                   i_cal_summary,
  // command port
  input  wire logic [`MQES_SEL_W-1:0] i_sel,
  input  wire logic                   i_rd,
  input  wire logic                   i_wr,
  input  wire logic [`MQES_W-1:0]     i_wdata,
  input  wire logic                   i_clear_status,
  input  wire logic                   i_status_preset,
  output logic      [`MQES_W-1:0]     o_rdata,
  output logic                        o_rvalid,
  // summaries to status byte
  output logic                        o_measurement_summary,
  output logic                        o_questionable_summary
);
  mqes_chan_if m_if ();
  mqes_chan_if q_if ();
  logic [`MQES_W-1:0] ms1_q, ms2_q, qs1_q, qs2_q;
  logic               bf1_q, bf2_q, cal1_q, cal2_q;
  logic [`MQES_W-1:0] m_cond, q_cond, rd_mux;
  logic [`MQES_W-1:0] rdata_q;
  logic               rvalid_q;

  // two-flop synchronisers; only the second flop is read
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ms1_q <= `MQES_ZERO;
      ms2_q <= `MQES_ZERO;
      qs1_q <= `MQES_ZERO;
      qs2_q <= `MQES_ZERO;
      {bf1_q, bf2_q, cal1_q, cal2_q} <= 4'h0;
    end else begin
      ms1_q <= i_meas_src;
      ms2_q <= ms1_q;
      qs1_q <= i_ques_src;
      qs2_q <= qs1_q;
      {bf1_q, bf2_q} <= {i_trace_buffer_full, bf1_q};
      {cal1_q, cal2_q} <= {i_cal_summary, cal1_q};
    end
  end

  // live conditions, never latched
  always_comb begin
    m_cond = ms2_q;
    m_cond[`MQES_BIT_BFULL] = bf2_q;
    q_cond = qs2_q;
    q_cond[`MQES_BIT_CAL] = cal2_q;
  end

  assign m_if.cond      = m_cond;
  assign m_if.wdata     = i_wdata;
  assign m_if.wr_rise   = i_wr && (i_sel == `MQES_SEL_MRISE);
  assign m_if.wr_fall   = i_wr && (i_sel == `MQES_SEL_MFALL);
  assign m_if.wr_mask   = i_wr && (i_sel == `MQES_SEL_MMASK);
  assign m_if.clr_event = i_clear_status || (i_rd && (i_sel == `MQES_SEL_MEVENT));
  assign m_if.preset    = i_status_preset;
  assign q_if.cond      = q_cond;
  assign q_if.wdata     = i_wdata;
  assign q_if.wr_rise   = i_wr && (i_sel == `MQES_SEL_QRISE);
  assign q_if.wr_fall   = i_wr && (i_sel == `MQES_SEL_QFALL);
  assign q_if.wr_mask   = i_wr && (i_sel == `MQES_SEL_QMASK);
  assign q_if.clr_event = i_clear_status || (i_rd && (i_sel == `MQES_SEL_QEVENT));
  assign q_if.preset    = i_status_preset;

  mqes_chan #(.PRESET_CLEARS_MASK(1'b0)) u_meas (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .ch        (m_if.chan)
  );
  mqes_chan #(.PRESET_CLEARS_MASK(1'b1)) u_ques (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .ch        (q_if.chan)
  );

  // read returns pre-clear contents; unknown selectors read zero
  assign rd_mux = (i_sel == `MQES_SEL_MCOND)  ? m_cond       :
                  (i_sel == `MQES_SEL_MRISE)  ? m_if.rise    :
                  (i_sel == `MQES_SEL_MFALL)  ? m_if.fall    :
                  (i_sel == `MQES_SEL_MEVENT) ? m_if.event_q :
                  (i_sel == `MQES_SEL_MMASK)  ? m_if.mask    :
                  (i_sel == `MQES_SEL_QCOND)  ? q_cond       :
                  (i_sel == `MQES_SEL_QRISE)  ? q_if.rise    :
                  (i_sel == `MQES_SEL_QFALL)  ? q_if.fall    :
                  (i_sel == `MQES_SEL_QEVENT) ? q_if.event_q :
                  (i_sel == `MQES_SEL_QMASK)  ? q_if.mask    : `MQES_ZERO;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q  <= `MQES_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_rd;
      if (i_rd) rdata_q <= rd_mux;
    end
  end

  assign o_rdata                = rdata_q;
  assign o_rvalid               = rvalid_q;
  assign o_measurement_summary  = m_if.summary;
  assign o_questionable_summary = q_if.summary;
endmodule // mqes_top

// ===== mqes_regs.svh
/*
 * register selectors, reset values and bit positions of the measurement and
 * questionable event status block. assumes the command decoder outside
 * presents a selector code with one-cycle read or write strobes.
 */
// Function
// - each channel condition is a live 16-bit read-only value, no latching
// - measurement condition bit 9 follows trace buffer full
// - questionable condition bit 8 follows calibration summary event
// - rise mask bit set lets a 0-to-1 condition change set the event bit
// - fall mask bit set lets a 1-to-0 condition change set the event bit
// - both masks set catch either edge; neither set catches none
// - edge masks writable per bit, readable anytime, reads leave them unchanged
// - power-up or preset sets rise masks to all ones, fall masks to zero
// - event bits latch until an explicit clearing operation
// - reading an event register returns it then clears it
// - measurement events cleared by power-up, clear-status and measurement query
// - measurement summary is OR of measurement events ANDed with its mask
// - questionable summary is OR of questionable events ANDed with its mask
// - mask bit 0 blocks its event, mask bit 1 passes it to summary
// - measurement enable mask unchanged by reads; cleared by power-up or writing zero
// - questionable events cleared by power-up, clear-status and questionable query
// - questionable enable mask unchanged by reads; cleared by power-up, preset, zero write
// - summary outputs follow current state combinationally, no latching
`ifndef MQES_REGS_SVH
`define MQES_REGS_SVH
`define MQES_W            16
`define MQES_SEL_W        4
`define MQES_SEL_MCOND    4'h0
`define MQES_SEL_MRISE    4'h1
`define MQES_SEL_MFALL    4'h2
`define MQES_SEL_MEVENT   4'h3
`define MQES_SEL_MMASK    4'h4
`define MQES_SEL_QCOND    4'h8
`define MQES_SEL_QRISE    4'h9
`define MQES_SEL_QFALL    4'ha
`define MQES_SEL_QEVENT   4'hb
`define MQES_SEL_QMASK    4'hc
`define MQES_RISE_RST     16'hffff
`define MQES_FALL_RST     16'h0000
`define MQES_ZERO         16'h0000
`define MQES_BIT_BFULL    9
`define MQES_BIT_CAL      8
// two sync flops plus the prev load before edges may be trusted
`define MQES_PRIME_W      3
`endif

// ===== mqes_pkg.sv
/*
 * types shared by the event status channel and its top.
 * assumes mqes_regs.svh supplies the widths.
 */
`include "mqes_regs.svh"
package mqes_pkg;
  typedef logic [`MQES_W-1:0] mqes_word_t;
endpackage

// ===== mqes_chan_if.sv
/*
 * carrier between the top and one event status channel.
 * assumes one clock, command strobes already decoded per channel.
 */
`timescale 1ns/1ns
`include "mqes_regs.svh"
interface mqes_chan_if;
  mqes_pkg::mqes_word_t cond;
  mqes_pkg::mqes_word_t wdata;
  logic                 wr_rise;
  logic                 wr_fall;
  logic                 wr_mask;
  logic                 clr_event;
  logic                 preset;
  mqes_pkg::mqes_word_t rise;
  mqes_pkg::mqes_word_t fall;
  mqes_pkg::mqes_word_t event_q;
  mqes_pkg::mqes_word_t mask;
  logic                 summary;
  modport top  (output cond, wdata, wr_rise, wr_fall, wr_mask, clr_event, preset,
                input rise, fall, event_q, mask, summary);
  modport chan (input cond, wdata, wr_rise, wr_fall, wr_mask, clr_event, preset,
                output rise, fall, event_q, mask, summary);
endinterface

// ===== mqes_chan.sv
/*
 * one event status channel: transition filter, latched events, enable mask.
 * assumes cond is already synchronised and strobes are one cycle wide.
 */
`timescale 1ns/1ns
`include "mqes_regs.svh"
module mqes_chan #(
  parameter bit PRESET_CLEARS_MASK = 1'b0
) (
  // clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_resetn,
  // channel carrier
  mqes_chan_if.chan   ch
);
  mqes_pkg::mqes_word_t prev_q, rise_q, fall_q, event_q, mask_q;
  logic [`MQES_PRIME_W-1:0] prime_q;
  mqes_pkg::mqes_word_t edges, event_d;

  // edges wait until the sync flops and prev hold the real condition, so a source
  // held high through reset is not taken for a rise
  assign edges   = prime_q[`MQES_PRIME_W-1] ? ((ch.cond & ~prev_q & rise_q) | (~ch.cond & prev_q & fall_q))
                                            : `MQES_ZERO;
  // set wins over clear so an edge coincident with a read is kept
  assign event_d = (ch.clr_event ? `MQES_ZERO : event_q) | edges;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q  <= `MQES_ZERO;
      prime_q <= {`MQES_PRIME_W{1'b0}};
    end else begin
      prev_q  <= ch.cond;
      prime_q <= {prime_q[`MQES_PRIME_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_q <= `MQES_RISE_RST;
      fall_q <= `MQES_FALL_RST;
    end else if (ch.preset) begin
      rise_q <= `MQES_RISE_RST;
      fall_q <= `MQES_FALL_RST;
    end else begin
      if (ch.wr_rise) rise_q <= ch.wdata;
      if (ch.wr_fall) fall_q <= ch.wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      event_q <= `MQES_ZERO;
      mask_q  <= `MQES_ZERO;
    end else begin
      event_q <= event_d;
      if (ch.preset && PRESET_CLEARS_MASK) mask_q <= `MQES_ZERO;
      else if (ch.wr_mask)                 mask_q <= ch.wdata;
    end
  end

  assign ch.rise    = rise_q;
  assign ch.fall    = fall_q;
  assign ch.event_q = event_q;
  assign ch.mask    = mask_q;
  assign ch.summary = |(event_q & mask_q);
endmodule // mqes_chan

// ===== mqes_sb_model.sv
/* status byte side model: takes the two summaries as bits.
   assumes summaries come straight from mqes_top. */
`timescale 1ns/1ns
module mqes_sb_model (
  // summaries in
  input  wire logic i_meas_sum,
  input  wire logic i_ques_sum,
  // status byte bits, never latched here
  output logic      o_sb_meas,
  output logic      o_sb_ques
);
  assign o_sb_meas = i_meas_sum;
  assign o_sb_ques = i_ques_sum;
endmodule // mqes_sb_model

// ===== mqes_monitor.sv
/* port checker for mqes_top.
   assumes one clock and the async active-low reset. */
`timescale 1ns/1ns
`include "mqes_regs.svh"
module mqes_monitor (
  // clock and reset
  input wire logic                   i_sys_clk,
  input wire logic                   i_resetn,
  // sources
  input wire logic [`MQES_W-1:0]     i_meas_src,
  input wire logic [`MQES_W-1:0]     i_ques_src,
  input wire logic                   i_trace_buffer_full,
  input wire logic                   i_cal_summary,
  // command port
  input wire logic [`MQES_SEL_W-1:0] i_sel,
  input wire logic                   i_rd,
  input wire logic                   i_wr,
  input wire logic [`MQES_W-1:0]     i_wdata,
  input wire logic                   i_clear_status,
  input wire logic                   i_status_preset,
  input wire logic [`MQES_W-1:0]     o_rdata,
  input wire logic                   o_rvalid,
  // summaries
  input wire logic                   o_measurement_summary,
  input wire logic                   o_questionable_summary
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_read_answered: assert property (i_rd |=> o_rvalid) else $error("read not answered");
  a_answer_cause: assert property (o_rvalid |-> $past(i_rd)) else $error("answer without read");
  a_mask_readback: assert property (
    (i_wr && i_sel == `MQES_SEL_MMASK) ##1 !i_wr ##1 (i_rd && !i_wr && i_sel == `MQES_SEL_MMASK)
    |=> o_rdata == $past(i_wdata, 3)) else $error("enable mask readback wrong");
  a_rise_readback: assert property (
    (i_wr && !i_status_preset && i_sel == `MQES_SEL_QRISE) ##1 !(i_wr || i_status_preset)
    ##1 (i_rd && !i_wr && i_sel == `MQES_SEL_QRISE) |=> o_rdata == $past(i_wdata, 3)) else $error("rise mask lost");
  a_zero_mask_blocks: assert property (
    i_wr && i_sel == `MQES_SEL_MMASK && i_wdata == `MQES_ZERO |=> !o_measurement_summary) else $error("mask leaks");
  a_preset_qmask: assert property (i_status_preset |=> !o_questionable_summary) else $error("preset kept mask");
  a_preset_rise: assert property (
    i_status_preset ##1 !i_wr ##1 (i_rd && !i_wr && i_sel == `MQES_SEL_MRISE) |=> o_rdata == `MQES_RISE_RST)
    else $error("preset rise mask wrong");
  a_cal_tracks: assert property (
    ($stable(i_cal_summary) && $past(i_resetn))[*5] ##0 (i_rd && i_sel == `MQES_SEL_QCOND)
    |=> o_rdata[`MQES_BIT_CAL] == $past(i_cal_summary)) else $error("cal bit not live");
endmodule // mqes_monitor
bind mqes_top mqes_monitor u_monitor (.i_sys_clk, .i_resetn, .i_meas_src, .i_ques_src, .i_trace_buffer_full,
  .i_cal_summary, .i_sel, .i_rd, .i_wr, .i_wdata, .i_clear_status, .i_status_preset, .o_rdata, .o_rvalid,
  .o_measurement_summary, .o_questionable_summary);

// ===== mqes_top_bench.sv
/* bench for mqes_top: register reads and writes against expected values.
   assumes mqes_monitor is bound to the top. */
`timescale 1ns/1ns
`include "mqes_regs.svh"
module mqes_top_bench;
  logic        i_sys_clk, i_resetn, i_trace_buffer_full, i_cal_summary, i_rd, i_wr;
  logic        i_clear_status, i_status_preset, o_rvalid, o_measurement_summary, o_questionable_summary;
  logic        sb_meas, sb_ques;
  logic [15:0] i_meas_src, i_ques_src, i_wdata, o_rdata;
  logic [3:0]  i_sel;
  logic [19:0] tbl [7] = '{20'h1ffff, 20'h20000, 20'h9ffff, 20'ha0000, 20'h40000, 20'hc0000, 20'h30000};
  int          err_total, check_count;
  mqes_top DUT (.i_sys_clk, .i_resetn, .i_meas_src, .i_ques_src, .i_trace_buffer_full, .i_cal_summary, .i_sel,
    .i_rd, .i_wr, .i_wdata, .i_clear_status, .i_status_preset, .o_rdata, .o_rvalid, .o_measurement_summary,
    .o_questionable_summary);
  mqes_sb_model sb (.i_meas_sum(o_measurement_summary), .i_ques_sum(o_questionable_summary),
    .o_sb_meas(sb_meas), .o_sb_ques(sb_ques));
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // inputs move 1 ns after the edge, so no race with the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one idle cycle after each strobe keeps a strobe from being set twice in one step
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    {i_sel, i_wdata, i_wr} = {sel, d, 1'b1};
    step(1);
    i_wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
    {i_sel, i_rd} = {sel, 1'b1};
    step(1);
    i_rd = 1'b0;
    check($sformatf("register %h", sel), o_rdata, exp);
    check("read valid", {15'h0, o_rvalid}, 16'h0001);
    step(1);
  endtask
  // sources pass two sync flops and the edge stage, four cycles covers it
  task automatic src(input logic [15:0] m, input logic [15:0] q, input logic tb, input logic cal);
    {i_meas_src, i_ques_src, i_trace_buffer_full, i_cal_summary} = {m, q, tb, cal};
    step(4);
  endtask
  task automatic sums(input logic [1:0] exp);
    check("summaries", {14'h0, sb_meas, sb_ques}, {14'h0, exp});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    err_total++;
    give_verdict();
  end
  initial begin
    {i_meas_src, i_ques_src, i_wdata, i_sel, i_trace_buffer_full, i_cal_summary} = '0;
    {i_rd, i_wr, i_clear_status, i_status_preset, i_resetn} = '0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_resetn = 1'b1;
    step(1);
    foreach (tbl[k]) rd(tbl[k][19:16], tbl[k][15:0]);
    src(16'h0001, 16'h0000, 1'b0, 1'b0);
    sums(2'b00);
    src(16'h0000, 16'h0000, 1'b0, 1'b0);
    rd(`MQES_SEL_MEVENT, 16'h0001);
    rd(`MQES_SEL_MEVENT, 16'h0000);
    wr(`MQES_SEL_MRISE, 16'h0000);
    src(16'h0001, 16'h0000, 1'b0, 1'b0);
    rd(`MQES_SEL_MEVENT, 16'h0000);
    wr(`MQES_SEL_MFALL, 16'h0001);
    src(16'h0000, 16'h0000, 1'b0, 1'b0);
    wr(`MQES_SEL_MMASK, 16'h0003);
    rd(`MQES_SEL_MMASK, 16'h0003);
    sums(2'b10);
    rd(`MQES_SEL_MEVENT, 16'h0001);
    sums(2'b00);
    wr(`MQES_SEL_MRISE, 16'h0001);
    src(16'h0001, 16'h0000, 1'b0, 1'b0);
    rd(`MQES_SEL_MEVENT, 16'h0001);
    src(16'h0001, 16'h0001, 1'b1, 1'b1);
    rd(`MQES_SEL_MCOND, 16'h0201);
    rd(`MQES_SEL_QCOND, 16'h0101);
    wr(`MQES_SEL_QRISE, 16'h0100);
    rd(`MQES_SEL_QRISE, 16'h0100);
    wr(`MQES_SEL_QMASK, 16'h0100);
    sums(2'b01);
    i_clear_status = 1'b1;
    step(1);
    i_clear_status = 1'b0;
    step(1);
    sums(2'b00);
    rd(`MQES_SEL_QEVENT, 16'h0000);
    src(16'h0001, 16'h0001, 1'b1, 1'b0);
    rd(`MQES_SEL_QCOND, 16'h0001);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h0000);
    i_status_preset = 1'b1;
    step(1);
    i_status_preset = 1'b0;
    step(1);
    rd(`MQES_SEL_MRISE, `MQES_RISE_RST);
    rd(`MQES_SEL_QFALL, `MQES_FALL_RST);
    rd(`MQES_SEL_QMASK, `MQES_ZERO);
    rd(`MQES_SEL_MMASK, 16'h0003);
    wr(`MQES_SEL_MMASK, `MQES_ZERO);
    rd(`MQES_SEL_MMASK, `MQES_ZERO);
    i_meas_src = 16'h0003;
    step(2);
    rd(`MQES_SEL_MEVENT, 16'h0000);
    rd(`MQES_SEL_MEVENT, 16'h0002);
    i_resetn = 1'b0;
    step(1);
    i_resetn = 1'b1;
    step(4);
    rd(`MQES_SEL_MEVENT, 16'h0000);
    rd(`MQES_SEL_QEVENT, 16'h0000);
    give_verdict();
  end
endmodule // mqes_top_bench
